// [design/dcc_top.sv]
// Checksum unit that sits in the datapath of one selected DMA channel
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dcc_top
	import dcc_pkg::*;
#(
	parameter int CH_W = 3                 // Width of the channel number
)(
	input  wire logic            clk,
	input  wire logic            rst_n,
	input  wire logic            ce,
	input  wire logic [7:0]      reg_addr,
	input  wire logic [31:0]     reg_wdata,
	input  wire logic            reg_wr,
	input  wire logic            reg_rd,
	output logic      [31:0]     reg_rdata,
	input  wire logic            src_valid,
	input  wire logic [CH_W-1:0] src_ch,
	input  wire logic [31:0]     src_data,
	output logic                 dst_valid,
	output logic      [CH_W-1:0] dst_ch,
	output logic      [31:0]     dst_data,
	output logic                 append_enable
);
	// Refuse any channel width other than the 3 bits of the control field
	if (CH_W != 3) begin : g_bad_ch_w
		$error("dcc_top: CH_W must be 3");
	end

	// Registers
	logic [31:0]     ctrl_reg;         // Control register image
	logic [31:0]     ctrl_next;
	logic [31:0]     data_reg;         // Checksum accumulator
	logic [31:0]     data_next;
	logic [31:0]     poly_reg;         // Feedback taps
	logic [31:0]     rdata_reg;        // Read data, one cycle late
	logic [31:0]     dst_data_reg;
	logic            dst_valid_reg;
	logic [CH_W-1:0] dst_ch_reg;

	// Control fields
	wire [1:0]       byte_order_select    = ctrl_reg[DCC_ORDER_LO +: 2];
	wire             write_reorder_select = ctrl_reg[DCC_WRORD_BIT];
	wire             bit_reflect_select   = ctrl_reg[DCC_REFL_BIT];
	wire [4:0]       poly_length_minus_one = ctrl_reg[DCC_POLYL_LO +: 5];
	wire             checksum_enable      = ctrl_reg[DCC_EN_BIT];
	wire             result_append        = ctrl_reg[DCC_APP_BIT];
	wire             checksum_type_select = ctrl_reg[DCC_TYP_BIT];
	wire [CH_W-1:0]  checksum_channel_select = ctrl_reg[DCC_CH_LO +: CH_W];

	// Address decode
	wire             hit_ctrl = (reg_addr == DCC_OFS_CTRL);
	wire             hit_data = (reg_addr == DCC_OFS_DATA);
	wire             hit_poly = (reg_addr == DCC_OFS_POLY);
	wire             wr_ctrl  = reg_wr && hit_ctrl;
	wire             wr_data  = reg_wr && hit_data;
	wire             wr_poly  = reg_wr && hit_poly;

	// Control write value: drop unimplemented bits
	wire [31:0]      ctrl_wmask = reg_wdata & DCC_CTRL_MASK;
	// Append cannot be set while reordered data is written back
	wire             wrord_new = ctrl_wmask[DCC_WRORD_BIT];
	wire [31:0]      ctrl_wval = wrord_new ?
		(ctrl_wmask & ~(32'h1 << DCC_APP_BIT)) : ctrl_wmask;

	// Next control value
	always_comb begin
		ctrl_next = wr_ctrl ? ctrl_wval : ctrl_reg;
	end

	// Channel selection and routing
	wire             ch_match = (src_ch == checksum_channel_select);
	wire             take     = src_valid && checksum_enable && ch_match;

	// Reordered copy of the source word
	logic [31:0]     reord_data;
	dcc_reorder u_reorder (
		.order_sel (byte_order_select),
		.data_in   (src_data),
		.data_out  (reord_data)
	);

	// Destination data: reordered only when routed and asked for
	wire [31:0]      dst_sel = (take && write_reorder_select) ?
		reord_data : src_data;

	// LFSR over one word, bit by bit, with length and reflection
	function automatic logic [31:0] lfsr_word(
		input logic [31:0] crc_in,
		input logic [31:0] din,
		input logic [31:0] taps,
		input logic [4:0]  len_m1,
		input logic        lsb_first
	);
		logic [31:0] crc;
		logic [31:0] mask;
		logic        fb;
		logic        bit_in;
		crc  = crc_in;
		mask = DCC_ALL_ONES >> (DCC_POLYL_MAX - len_m1);
		for (int i = 0; i < 32; i++) begin
			// Reflected takes bit 0 first, else bit 31 first
			bit_in = lsb_first ? din[i] : din[31 - i];
			fb     = crc[len_m1] ^ bit_in;
			crc    = (crc << 1) & mask;
			if (fb) begin
				crc = crc ^ (taps & mask);
			end
		end
		return crc;
	endfunction

	// Bit reversal within each half-word
	function automatic logic [31:0] half_reflect(input logic [31:0] d);
		logic [31:0] r;
		r = '0;
		for (int i = 0; i < 16; i++) begin
			r[i]      = d[15 - i];
			r[16 + i] = d[31 - i];
		end
		return r;
	endfunction

	// Ones' complement sum of both half-words into the accumulator
	function automatic logic [15:0] ip_sum(
		input logic [15:0] acc,
		input logic [31:0] d
	);
		logic [17:0] s;
		logic [16:0] f;
		s = {2'b00, acc} + {2'b00, d[31:16]} + {2'b00, d[15:0]};
		f = {1'b0, s[15:0]} + {15'h0000, s[17:16]};
		return f[15:0] + {15'h0000, f[16]};
	endfunction

	// Checksum inputs
	wire [31:0]      ip_in   = bit_reflect_select ?
		half_reflect(reord_data) : reord_data;
	wire [31:0]      lfsr_res = lfsr_word(data_reg, reord_data, poly_reg,
		poly_length_minus_one, bit_reflect_select);
	wire [15:0]      ip_res   = ip_sum(data_reg[15:0], ip_in);
	wire [31:0]      calc_res = checksum_type_select ?
		{16'h0000, ip_res} : lfsr_res;

	// Next accumulator: software seed wins over a data word
	always_comb begin
		if (wr_data) begin
			data_next = reg_wdata;
		end else if (take) begin
			data_next = calc_res;
		end else begin
			data_next = data_reg;
		end
	end

	// Read mux, zero for unmapped addresses
	wire [31:0]      rd_mux = hit_ctrl ? (ctrl_reg & DCC_CTRL_MASK) :
	                          hit_data ? data_reg :
	                          hit_poly ? poly_reg : 32'h00000000;

	// Register file and accumulator
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= DCC_CTRL_RESET;
			data_reg <= DCC_DATA_RESET;
			poly_reg <= DCC_POLY_RESET;
		end else if (ce) begin
			ctrl_reg <= ctrl_next;
			data_reg <= data_next;
			if (wr_poly) begin
				poly_reg <= reg_wdata;
			end
		end
	end

	// Read data for the cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 32'h00000000;
		end else if (ce) begin
			rdata_reg <= reg_rd ? rd_mux : 32'h00000000;
		end
	end

	// Destination stage, one cycle behind the source
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dst_valid_reg <= 1'b0;
			dst_ch_reg    <= '0;
			dst_data_reg  <= 32'h00000000;
		end else if (ce) begin
			dst_valid_reg <= src_valid;
			dst_ch_reg    <= src_ch;
			dst_data_reg  <= dst_sel;
		end
	end

	// Outputs
	assign reg_rdata     = rdata_reg;
	assign dst_valid     = dst_valid_reg;
	assign dst_ch        = dst_ch_reg;
	assign dst_data      = dst_data_reg;
	assign append_enable = result_append && checksum_enable;
endmodule // dcc_top
`default_nettype wire

// [design/dcc_pkg.sv]
// Package with register map, field layout and widths of the checksum unit
package dcc_pkg;
	// Register byte offsets
	localparam logic [7:0]  DCC_OFS_CTRL    = 8'h00; // Checksum control
	localparam logic [7:0]  DCC_OFS_DATA    = 8'h04; // Seed and result
	localparam logic [7:0]  DCC_OFS_POLY    = 8'h08; // Feedback taps
	// Control field positions
	localparam int          DCC_ORDER_LO    = 28;    // Byte order, two bits
	localparam int          DCC_WRORD_BIT   = 27;    // Write reordered data
	localparam int          DCC_REFL_BIT    = 24;    // Bit reflection
	localparam int          DCC_POLYL_LO    = 8;     // Poly length minus one
	localparam int          DCC_EN_BIT      = 7;     // Checksum enable
	localparam int          DCC_APP_BIT     = 6;     // Result append
	localparam int          DCC_TYP_BIT     = 5;     // Checksum type
	localparam int          DCC_CH_LO       = 0;     // Channel select
	// Implemented control bits, register reset values and LFSR mask limits
	localparam logic [31:0] DCC_CTRL_MASK   = 32'h39001FE7;
	localparam logic [31:0] DCC_CTRL_RESET  = 32'h00000000;
	localparam logic [31:0] DCC_DATA_RESET  = 32'h00000000;
	localparam logic [31:0] DCC_POLY_RESET  = 32'h00000000;
	localparam logic [31:0] DCC_ALL_ONES    = 32'hFFFFFFFF;
	localparam logic [4:0]  DCC_POLYL_MAX   = 5'h1F;
	// Byte order encodings
	localparam logic [1:0]  DCC_ORD_NONE    = 2'h0;
	localparam logic [1:0]  DCC_ORD_WORD    = 2'h1;
	localparam logic [1:0]  DCC_ORD_HALF    = 2'h2;
	localparam logic [1:0]  DCC_ORD_BYHALF  = 2'h3;
endpackage : dcc_pkg

// [design/dcc_reorder.sv]
// Byte and half-word reordering of one 32-bit data word
`timescale 1ns/1ps
`default_nettype none
module dcc_reorder
	import dcc_pkg::*;
(
	input  wire logic [1:0]  order_sel,
	input  wire logic [31:0] data_in,
	output logic      [31:0] data_out
);
	// Candidate orders of the four bytes
	wire [31:0] word_rev   = {data_in[7:0], data_in[15:8],
	                          data_in[23:16], data_in[31:24]};
	wire [31:0] half_swap  = {data_in[15:0], data_in[31:16]};
	wire [31:0] half_brev  = {data_in[23:16], data_in[31:24],
	                          data_in[7:0], data_in[15:8]};

	// Select one order
	always_comb begin
		case (order_sel)
			DCC_ORD_NONE:   data_out = data_in;
			DCC_ORD_WORD:   data_out = word_rev;
			DCC_ORD_HALF:   data_out = half_swap;
			DCC_ORD_BYHALF: data_out = half_brev;
			default:        data_out = data_in;
		endcase
	end
endmodule // dcc_reorder
`default_nettype wire

// [testbench/dcc_top_sva.sv]
// Port checker of the checksum unit with its bind
`timescale 1ns/1ps
`default_nettype none
module dcc_top_chk
	import dcc_pkg::*;
#(
	parameter int CH_W = 3 // Width of the channel number
)(
	input wire logic            clk,
	input wire logic            rst_n,
	input wire logic            ce,
	input wire logic [7:0]      reg_addr,
	input wire logic [31:0]     reg_wdata,
	input wire logic            reg_wr,
	input wire logic            reg_rd,
	input wire logic [31:0]     reg_rdata,
	input wire logic            src_valid,
	input wire logic [CH_W-1:0] src_ch,
	input wire logic [31:0]     src_data,
	input wire logic            dst_valid,
	input wire logic [CH_W-1:0] dst_ch,
	input wire logic [31:0]     dst_data,
	input wire logic            append_enable
);
	logic [31:0] sh_reg; // Shadow of the control register
	wire logic   sel;    // Word goes through the checksum
	assign sel = sh_reg[DCC_EN_BIT] && src_ch == sh_reg[CH_W-1:0];
	// Track control writes, append dropped when write reorder is set
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			sh_reg <= 32'h0;
		else if (ce && reg_wr && reg_addr == DCC_OFS_CTRL)
			sh_reg <= reg_wdata & DCC_CTRL_MASK & ~(reg_wdata[27] ? 32'h40 : 32'h0);
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_dst_follow: assert property (ce |=> dst_valid == $past(src_valid))
		else $error("dst_valid does not follow src_valid");
	a_ch_follow: assert property (ce && src_valid |=> dst_ch == $past(src_ch))
		else $error("dst_ch does not follow src_ch");
	a_pass_raw: assert property (ce && src_valid && !sel |=> dst_data == $past(src_data))
		else $error("unselected word altered");
	a_wbo_clear: assert property (ce && src_valid && sel && !sh_reg[27] |=> dst_data == $past(src_data))
		else $error("word reordered with write reorder clear");
	a_half_swap: assert property (ce && src_valid && sel && sh_reg[27]
		&& sh_reg[29:28] == DCC_ORD_HALF
		|=> dst_data == {$past(src_data[15:0]), $past(src_data[31:16])})
		else $error("half-word swap wrong");
	a_ce_hold: assert property (!ce |=> $stable(dst_data) && $stable(dst_valid)
		&& $stable(reg_rdata))
		else $error("state moved while clock enable low");
	a_append_out: assert property (append_enable == (sh_reg[6] && sh_reg[7]))
		else $error("append_enable wrong");
	a_rd_idle: assert property (ce && !reg_rd |=> reg_rdata == 32'h0)
		else $error("read data outside read cycle");
	a_ctrl_read: assert property (ce && reg_rd && reg_addr == DCC_OFS_CTRL |=> reg_rdata == $past(sh_reg))
		else $error("control read back wrong");
	a_unmapped: assert property (ce && reg_rd && reg_addr > DCC_OFS_POLY |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
endmodule // dcc_top_chk
bind dcc_top dcc_top_chk #(.CH_W(CH_W)) i_chk (.clk(clk), .rst_n(rst_n), .ce(ce),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .src_valid(src_valid), .src_ch(src_ch), .src_data(src_data),
	.dst_valid(dst_valid), .dst_ch(dst_ch), .dst_data(dst_data), .append_enable(append_enable));
`default_nettype wire

// [testbench/dcc_dma_model.sv]
// DMA channel source model feeding whole words
`timescale 1ns/1ps
`default_nettype none
module dcc_dma_model (
	input  wire logic   clk,
	output logic        src_valid,
	output logic [2:0]  src_ch,
	output logic [31:0] src_data
);
	// Idle source at time zero
	initial begin
		src_valid = 1'b0;
		src_ch = 3'h0;
		src_data = 32'h0;
	end
	// One whole aligned word, line scrambled once released
	task automatic send(input logic [2:0] ch, input logic [31:0] d);
		@(posedge clk);
		src_valid <= 1'b1;
		src_ch <= ch;
		src_data <= d;
		@(posedge clk);
		src_valid <= 1'b0;
		src_data <= ~d;
	endtask
endmodule // dcc_dma_model
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench of the checksum unit
`timescale 1ns/1ps
`default_nettype none
module tb;
	import dcc_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        ce = 1'b1;       // Clock enable
	logic        rd_d = 1'b0;     // Read result due this cycle
	logic [31:0] reg_rdata, src_data, dst_data;
	logic        src_valid, dst_valid, append_enable;
	logic [2:0]  src_ch, dst_ch;
	logic [31:0] seed = 32'h0000003D; // Random state
	logic [31:0] exp_q[$];           // Expected results in order
	int          num_errors = 0;
	int          checked = 0;
	dcc_top i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.src_valid(src_valid), .src_ch(src_ch), .src_data(src_data), .dst_valid(dst_valid),
		.dst_ch(dst_ch), .dst_data(dst_data), .append_enable(append_enable));
	dcc_dma_model i_dma (.clk(clk), .src_valid(src_valid), .src_ch(src_ch), .src_data(src_data));
	initial forever #10 clk = ~clk;
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Byte reordering of a word
	function automatic logic [31:0] ord(input logic [1:0] o, input logic [31:0] d);
		case (o)
			2'h1: return {d[7:0], d[15:8], d[23:16], d[31:24]};
			2'h2: return {d[15:0], d[31:16]};
			2'h3: return {d[23:16], d[31:24], d[7:0], d[15:8]};
			default: return d;
		endcase
	endfunction
	// Checksum of one reordered word from seed c, taps p, control r
	function automatic logic [31:0] sum(input logic [31:0] c, p, d, r);
		logic [31:0] m;
		logic [16:0] s;
		logic [15:0] h;
		logic        b;
		m = 32'((64'h1 << (r[12:8] + 1)) - 1);
		s = {1'b0, c[15:0]};
		for (int i = 0; i < 32; i++) begin
			b = c[r[12:8]] ^ d[r[DCC_REFL_BIT] ? i : 31 - i];
			c = (c << 1) & m;
			if (b) c = c ^ (p & m);
		end
		for (int i = 0; i < 2; i++) begin
			h = i ? d[15:0] : d[31:16];
			if (r[DCC_REFL_BIT]) h = {<<{h}};
			s = {1'b0, s[15:0]} + h;
			s = {1'b0, s[15:0]} + s[16];
		end
		return r[DCC_TYP_BIT] ? {16'h0, s[15:0]} : c;
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		// Notes never answered count as mismatches
		num_errors += exp_q.size();
		$display("checked=%0d num_errors=%0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Take the oldest note whenever a result appears
	always @(posedge clk) begin
		rd_d <= reg_rd;
		if (rd_d || dst_valid === 1'b1) begin
			if (exp_q.size() == 0) num_errors++;
			else chk(rd_d ? reg_rdata : dst_data, exp_q.pop_front());
		end
	end
	// Bound on the whole run
	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		print_verdict();
	end
	initial begin
		logic [31:0] r, c, p, d;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rd(DCC_OFS_CTRL, DCC_CTRL_RESET);
		rd(DCC_OFS_DATA, DCC_DATA_RESET);
		rd(8'h0C, 32'h0);
		for (int k = 0; k < 40; k++) begin
			r = xs();
			r[29:28] = k[1:0];
			r[DCC_TYP_BIT] = k[2];
			r[DCC_EN_BIT] = k < 30;
			c = xs();
			p = xs();
			d = xs();
			wr(DCC_OFS_POLY, p);
			wr(DCC_OFS_DATA, c);
			wr(DCC_OFS_CTRL, r);
			exp_q.push_back(r[7] && r[27] ? ord(r[29:28], d) : d);
			i_dma.send(r[2:0], d);
			exp_q.push_back(~d);
			i_dma.send(r[2:0] ^ 3'h1, ~d);
			// Seed write under a low clock enable must not land
			@(posedge clk);
			ce <= 1'b0;
			wr(DCC_OFS_DATA, ~c);
			ce <= 1'b1;
			rd(DCC_OFS_DATA, r[7] ? sum(c, p, ord(r[29:28], d), r) : c);
			rd(DCC_OFS_CTRL, r & DCC_CTRL_MASK & ~(r[27] ? 32'h40 : 32'h0));
		end
		repeat (3) @(posedge clk);
		print_verdict();
	end
endmodule // tb
`default_nettype wire
